// [rtl/msi_ext_cfg_regs.vh]
// Register offsets, field positions and reset values for the interrupt message and window block
`ifndef MSI_EXT_CFG_REGS_VH
`define MSI_EXT_CFG_REGS_VH
`define OFF_LOW_ADDR 12'h0d4
`define OFF_HIGH_ADDR 12'h0d8
`define OFF_MSG_VALUE 12'h0dc
`define OFF_PTR 12'h0f8
`define OFF_WINDOW 12'h0fc
`define OFF_CAP_CTRL 12'h0d0
`define CAP_EN_BIT 16
`define LOW_ADDR_MASK 32'hffff_fffc
`define MSG_VALUE_MASK 32'h0000_ffff
`define PTR_MASK 32'h0000_0ffc
`define PTR_REG_LSB 2
`define PTR_REG_MSB 7
`define PTR_EXT_LSB 8
`define PTR_EXT_MSB 11
`define RESET_ZERO 32'h0000_0000
`define ZERO_HI_32 32'h0000_0000
`define ZERO_DATA_HI 16'h0000
`endif

// [rtl/msi_and_ext_cfg_window_regs.v]
// Interrupt message address/data registers and indirect configuration window
// Function
// - Low interrupt address holds a writable field in bits 31:2, resets to zero, bits 1:0 read zero.
// - High interrupt address is a full 32-bit writable register resetting to zero.
// - A nonzero high address makes the interrupt write use a 64-bit address.
// - A zero high address makes the interrupt write use the 32-bit low address only.
// - Message value is a writable 16-bit field in bits 15:0, upper bits read zero.
// - Pointer bits 7:2 select the configuration dword that the window reaches.
// - Pointer bits 11:8 extend that selection into extended space, other bits reserved.
// - A window read returns the current value of the register that the pointer selects.
// - A window write updates the register that the pointer selects.
// - Window accesses pass their byte enables unchanged to the selected register.
// - Window accesses from the SMBus path read zero and write nothing.
// - Interrupt writes are issued only while the enable bit of the capability register is set.
`include "msi_ext_cfg_regs.vh"

module msi_and_ext_cfg_window_regs (
	input wire clk,
	input wire sys_rst,
	// Configuration access port from the function's config decoder
	input wire cfg_req,
	input wire cfg_wr,
	input wire cfg_smbus,
	input wire [11:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg cfg_ack,
	output reg [31:0] cfg_rdata,
	// Redirected access to the rest of configuration space
	output reg fwd_req,
	output reg fwd_wr,
	output reg [11:0] fwd_addr,
	output reg [3:0] fwd_be,
	output reg [31:0] fwd_wdata,
	input wire fwd_ack,
	input wire [31:0] fwd_rdata,
	// Interrupt message generation
	input wire irq_capability_control_en,
	input wire irq_request,
	output reg irq_wr_valid,
	output reg irq_wr_is_64,
	output reg [63:0] irq_wr_addr,
	output reg [31:0] irq_wr_data,
	output wire irq_ignored
);

localparam st_idle = 3'b001;
localparam st_fwd = 3'b010;
localparam st_done = 3'b100;

reg [31:0] irq_msg_low_address_r;
reg [31:0] irq_msg_high_address_r;
reg [31:0] irq_msg_value_r;
reg [31:0] indirect_cfg_pointer_r;
reg [2:0] state_r;
reg [31:0] bemask;
reg [31:0] local_rd;
reg local_hit;
integer i;

////////////////////////////////////////////////////////////////////////////////
// Byte-enable expansion

always @* begin
	for (i = 0; i < 32; i = i + 1) begin
		bemask[i] = cfg_be[i / 8];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Local register read decode

always @* begin
	local_hit = 1'b1;
	local_rd = `RESET_ZERO;
	if (cfg_addr == `OFF_LOW_ADDR) begin
		local_rd = irq_msg_low_address_r & `LOW_ADDR_MASK;
	end else if (cfg_addr == `OFF_HIGH_ADDR) begin
		local_rd = irq_msg_high_address_r;
	end else if (cfg_addr == `OFF_MSG_VALUE) begin
		local_rd = irq_msg_value_r & `MSG_VALUE_MASK;
	end else if (cfg_addr == `OFF_PTR) begin
		local_rd = indirect_cfg_pointer_r & `PTR_MASK;
	end else if (cfg_addr == `OFF_WINDOW) begin
		local_rd = `RESET_ZERO;
	end else begin
		local_hit = 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Access sequencing
// Window accesses not from SMBus take the forward path and wait for its ack; everything
// else answers one cycle after the request. Unmapped offsets read zero.

always @(posedge clk) begin
	if (sys_rst) begin
		irq_msg_low_address_r <= `RESET_ZERO;
		irq_msg_high_address_r <= `RESET_ZERO;
		irq_msg_value_r <= `RESET_ZERO;
		indirect_cfg_pointer_r <= `RESET_ZERO;
		state_r <= st_idle;
		cfg_ack <= 1'b0;
		cfg_rdata <= `RESET_ZERO;
		fwd_req <= 1'b0;
		fwd_wr <= 1'b0;
		fwd_addr <= 12'h000;
		fwd_be <= 4'h0;
		fwd_wdata <= `RESET_ZERO;
	end else begin
		cfg_ack <= 1'b0;
		case (state_r)
		st_idle: begin
			if (cfg_req) begin
				if (cfg_addr == `OFF_WINDOW && !cfg_smbus) begin
					// Pointer value selects the dword; be passed as-is
					fwd_req <= 1'b1;
					fwd_wr <= cfg_wr;
					fwd_addr <= {indirect_cfg_pointer_r[`PTR_EXT_MSB:`PTR_EXT_LSB],
						indirect_cfg_pointer_r[`PTR_REG_MSB:`PTR_REG_LSB], 2'b00};
					fwd_be <= cfg_be;
					fwd_wdata <= cfg_wdata;
					state_r <= st_fwd;
				end else begin
					// Local register access; SMBus window access reads zero, writes dropped
					cfg_ack <= 1'b1;
					cfg_rdata <= cfg_wr ? `RESET_ZERO : local_rd;
					state_r <= st_done;
					if (cfg_wr && local_hit) begin
						if (cfg_addr == `OFF_LOW_ADDR) begin
							irq_msg_low_address_r <= ((irq_msg_low_address_r & ~bemask) |
								(cfg_wdata & bemask)) & `LOW_ADDR_MASK;
						end else if (cfg_addr == `OFF_HIGH_ADDR) begin
							irq_msg_high_address_r <= (irq_msg_high_address_r & ~bemask) |
								(cfg_wdata & bemask);
						end else if (cfg_addr == `OFF_MSG_VALUE) begin
							irq_msg_value_r <= ((irq_msg_value_r & ~bemask) |
								(cfg_wdata & bemask)) & `MSG_VALUE_MASK;
						end else if (cfg_addr == `OFF_PTR) begin
							indirect_cfg_pointer_r <= ((indirect_cfg_pointer_r & ~bemask) |
								(cfg_wdata & bemask)) & `PTR_MASK;
						end
					end
				end
			end
		end
		st_fwd: begin
			if (fwd_ack) begin
				fwd_req <= 1'b0;
				cfg_ack <= 1'b1;
				cfg_rdata <= fwd_wr ? `RESET_ZERO : fwd_rdata;
				state_r <= st_done;
			end
		end
		st_done: begin
			// One idle cycle so a held request is not taken twice
			state_r <= st_idle;
		end
		default: begin
			state_r <= st_idle;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt message write

assign irq_ignored = irq_request & ~irq_capability_control_en;

always @(posedge clk) begin
	if (sys_rst) begin
		irq_wr_valid <= 1'b0;
		irq_wr_is_64 <= 1'b0;
		irq_wr_addr <= {`ZERO_HI_32, `RESET_ZERO};
		irq_wr_data <= `RESET_ZERO;
	end else begin
		irq_wr_valid <= irq_request & irq_capability_control_en;
		if (irq_request && irq_capability_control_en) begin
			irq_wr_is_64 <= |irq_msg_high_address_r;
			if (|irq_msg_high_address_r) begin
				irq_wr_addr <= {irq_msg_high_address_r,
					irq_msg_low_address_r[31:2], 2'b00};
			end else begin
				irq_wr_addr <= {`ZERO_HI_32, irq_msg_low_address_r[31:2], 2'b00};
			end
			irq_wr_data <= {`ZERO_DATA_HI, irq_msg_value_r[15:0]};
		end
	end
end

endmodule

// [dv/msi_cfg_checker.sv]
// Port-level assertions for the interrupt message and window block
module msi_cfg_checker (
	input wire clk,
	input wire sys_rst,
	input wire cfg_smbus, cfg_ack, fwd_req, fwd_wr, fwd_ack,
	input wire [11:0] cfg_addr,
	input wire [31:0] cfg_rdata, fwd_rdata, irq_wr_data,
	input wire irq_capability_control_en, irq_request, irq_wr_valid, irq_wr_is_64, irq_ignored,
	input wire [63:0] irq_wr_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_IRQ_GO:
	assert property (irq_request && irq_capability_control_en |=> irq_wr_valid) else $error("no irq");
	AST_IRQ_ONLY:
	assert property (irq_wr_valid |-> $past(irq_request && irq_capability_control_en))
		else $error("stray irq");
	AST_IGNORED:
	assert property (irq_ignored == (irq_request && !irq_capability_control_en))
		else $error("ignored flag wrong");
	AST_WIDTH:
	assert property (irq_wr_valid |-> irq_wr_is_64 == (irq_wr_addr[63:32] != 32'h0))
		else $error("address width wrong");
	AST_LOW_ZERO:
	assert property (irq_wr_valid |-> irq_wr_addr[1:0] == 2'h0 && irq_wr_data[31:16] == 16'h0)
		else $error("zero bits set");
	AST_SMB_NOFWD:
	assert property ($rose(fwd_req) |-> $past(!cfg_smbus && cfg_addr == 12'h0fc))
		else $error("bad forward");
	AST_FWD_HOLD:
	assert property (fwd_req && !fwd_ack |=> fwd_req) else $error("forward dropped");
	AST_WIN_RD:
	assert property (fwd_req && fwd_ack && !fwd_wr |=> cfg_ack && cfg_rdata == $past(fwd_rdata))
		else $error("window read wrong");
endmodule
bind msi_and_ext_cfg_window_regs msi_cfg_checker u_msi_cfg_checker (.*);

// [dv/cfg_space_model.sv]
// Behavioural model of the configuration space behind the window
module cfg_space_model (
	input wire clk,
	input wire fwd_req,
	input wire fwd_wr,
	input wire [11:0] fwd_addr,
	input wire [3:0] fwd_be,
	input wire [31:0] fwd_wdata,
	output logic fwd_ack = 1'b0,
	output logic [31:0] fwd_rdata = 32'h0,
	input int dly
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:1023];
	int n = 0;
	always @(posedge clk) begin
		fwd_ack <= 1'b0;
		// Idle data toggles so a stale value never looks valid
		fwd_rdata <= ~fwd_rdata;
		if (fwd_req && !fwd_ack) begin
			n <= n + 1;
			if (n >= dly) begin
				n <= 0;
				fwd_ack <= 1'b1;
				if (!fwd_wr)
					fwd_rdata <= mem[fwd_addr[11:2]];
				for (int i = 0; i < 4; i++)
					if (fwd_wr && fwd_be[i])
						mem[fwd_addr[11:2]][8*i+:8] <= fwd_wdata[8*i+:8];
			end
		end
	end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the interrupt message and window block
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, cfg_req = 0, cfg_wr = 0, cfg_smbus = 0;
	logic irq_capability_control_en = 0, irq_request = 0;
	logic [11:0] cfg_addr = 0;
	logic [3:0] cfg_be = 0;
	logic [31:0] cfg_wdata = 0, rd;
	wire cfg_ack, fwd_req, fwd_wr, fwd_ack, irq_wr_valid, irq_wr_is_64, irq_ignored;
	wire [31:0] cfg_rdata, fwd_wdata, fwd_rdata, irq_wr_data;
	wire [11:0] fwd_addr;
	wire [3:0] fwd_be;
	wire [63:0] irq_wr_addr;
	int errors = 0, checks_done = 0, cyc = 0, dly = 0;
	always #12.5 clk = ~clk;
	msi_and_ext_cfg_window_regs u_msi_and_ext_cfg_window_regs (.*);
	cfg_space_model u_cfg_space_model (.*);
	////////////////////////////////////////////////////////////////
	task acc(input logic w, s, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		@(negedge clk);
		{cfg_req, cfg_wr, cfg_smbus, cfg_addr, cfg_wdata, cfg_be} = {1'b1, w, s, a, d, b};
		for (int k = 0; k < 20 && cfg_ack !== 1'b1; k++) @(negedge clk);
		rd = cfg_rdata;
		cfg_req = 0;
		// One dead cycle follows every answer
		@(negedge clk);
	endtask
	task t_regs;
		logic [11:0] a [4] = '{12'h0d4, 12'h0d8, 12'h0dc, 12'h0f8};
		logic [31:0] m [4] = '{32'hffff_fffc, 32'hffff_ffff, 32'h0000_ffff, 32'h0000_0ffc};
		for (int i = 0; i < 4; i++) begin
			acc(0, 0, a[i], 0, 4'hf);
			`CHK("reset", 32'h0, rd)
			acc(1, 0, a[i], 32'hffff_ffff, 4'hf);
			acc(0, 0, a[i], 0, 4'hf);
			`CHK("mask", m[i], rd)
		end
		acc(1, 0, 12'h0c0, 32'hffff_ffff, 4'hf);
		acc(0, 0, 12'h0c0, 0, 4'hf);
		`CHK("unmapped", 32'h0, rd)
		$display("test regs done");
	endtask
	task t_win;
		dly = 3;
		// Pointer kept off its own offsets and off the global space pair
		acc(1, 0, 12'h0f8, 32'h104, 4'hf);
		acc(1, 0, 12'h0fc, 32'h1122_3344, 4'hf);
		acc(1, 0, 12'h0fc, 32'haabb_ccdd, 4'h5);
		dly = 0;
		acc(1, 0, 12'h0f8, 32'h040, 4'hf);
		acc(1, 0, 12'h0fc, 32'h5, 4'hf);
		`CHK("sel", 32'h5, u_cfg_space_model.mem[16])
		acc(1, 0, 12'h0f8, 32'h104, 4'hf);
		acc(0, 0, 12'h0fc, 0, 4'hf);
		`CHK("win", 32'h11bb_33dd, rd)
		$display("test window done");
	endtask
	task t_smb;
		acc(0, 1, 12'h0fc, 0, 4'hf);
		`CHK("smb rd", 32'h0, rd)
		acc(1, 1, 12'h0fc, 32'hffff_ffff, 4'hf);
		`CHK("smb wr", 32'h11bb_33dd, u_cfg_space_model.mem[65])
		$display("test smbus done");
	endtask
	task irq(input logic e, input logic [63:0] ea);
		@(negedge clk);
		irq_capability_control_en = e;
		irq_request = 1;
		#1 `CHK("ignored", ~e, irq_ignored)
		@(negedge clk);
		irq_request = 0;
		`CHK("valid", e, irq_wr_valid)
		if (e) begin
			`CHK("addr", ea, irq_wr_addr)
			`CHK("is64", |ea[63:32], irq_wr_is_64)
			`CHK("data", 32'hbeef, irq_wr_data)
		end
	endtask
	task t_irq;
		acc(1, 0, 12'h0d4, 32'h1234_5677, 4'hf);
		acc(1, 0, 12'h0d8, 32'h0, 4'hf);
		acc(1, 0, 12'h0dc, 32'hdead_beef, 4'hf);
		irq(1, 64'h1234_5674);
		acc(1, 0, 12'h0d8, 32'h1, 4'hf);
		irq(1, 64'h1_1234_5674);
		irq(0, 64'h0);
		$display("test irq done");
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_sim;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk) sys_rst = 0;
		t_regs;
		t_win;
		t_smb;
		t_irq;
		end_sim;
	end
endmodule
